// >>> design/ces_pkg.sv
`default_nettype none

package ces_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned SLOW_WAIT_S = 20;
    localparam int unsigned SLOW_WAIT_CYC = SLOW_WAIT_S * CLK_HZ;
    localparam int unsigned FLASH_HALF_MS = 500;
    localparam int unsigned FLASH_HALF_CYC = (CLK_HZ / 1000) * FLASH_HALF_MS;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ERRCODE = 8'h08;
    localparam logic [7:0] OFS_USERERR = 8'h0C;

    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_CLEAR_BIT = 1;
    localparam logic CTRL_RUN_RST = 1'b1;
    localparam int USER_FATAL_BIT = 16;
    localparam int USER_NUM_MSB = 8;
    localparam logic [15:0] USER_FATAL_BASE = 16'hC100;
    localparam logic [15:0] USER_NONFATAL_BASE = 16'h4100;
    localparam logic [15:0] CODE_NONE = 16'h0000;

    // status word layout
    localparam int ST_STATE_LSB = 0;
    localparam int ST_LAMP_LSB = 4;
    localparam int ST_TOOL_BIT = 7;
    localparam int ST_OUTOFF_BIT = 8;
    localparam int ST_NONFATAL_BIT = 9;
    localparam int ST_PWRDN_BIT = 10;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CES_STANDBY   = 3'b000,
        CES_CFG_STBY  = 3'b001,
        CES_IDLE      = 3'b010,
        CES_RUN       = 3'b011,
        CES_FATAL     = 3'b100,
        CES_CPU_ERR   = 3'b101,
        CES_CPU_RESET = 3'b110
    } ces_state_e;

    typedef struct packed {
        logic rdy;
        logic run;
        logic err;
    } ces_lamp_s;

    localparam ces_lamp_s LAMPS_OFF = 3'b000;

endpackage

`default_nettype wire

// >>> design/ces_error_status.sv
// Operation
// - watchdog timeout in run: only fault lit, no code, tool refused
// - fatal error: ready and fault lit, run off, tool still accepted
// - cpu reset: all lamps off, no flag or code, tool refused
// - expansion rack power loss: stop and run own power-down procedure
// - cyclic servicing starts only after every module is recognised
// - run startup mode: standby with lamps off until modules recognised
// - power-on config error: standby, fault lit, left only by power-up
// - slow expansion unit attached: standby extended for 20 s recognition
// - simultaneous errors: only the most serious code is stored
// - fatal error clears io memory unless raised by user fatal instruction
// - whenever operation stops all outputs are forced off
// - non-fatal error: keep running, ready and run lit, fault flashing
`timescale 1ns/1ps
`default_nettype none

module ces_error_status #(
    parameter int unsigned SLOW_WAIT = ces_pkg::SLOW_WAIT_CYC,
    parameter int unsigned FLASH_HALF = ces_pkg::FLASH_HALF_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic mods_recognised,
    input wire logic slow_unit_present,
    input wire logic cfg_error,
    input wire logic wdt_timeout,
    input wire logic cpu_reset_cond,
    input wire logic rack_power_lost,
    input wire logic fatal_valid,
    input wire logic [15:0] fatal_code,
    input wire logic nonfatal_valid,
    input wire logic [15:0] nonfatal_code,
    output var ces_pkg::ces_lamp_s lamps,
    output logic tool_connect_ok,
    output logic cycle_enable,
    output logic outputs_off,
    output logic io_mem_clear,
    output logic power_down_req,
    output logic [15:0] error_code_word
);
    import ces_pkg::*;

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    logic dp_wr_reg;
    logic [7:0] dp_addr_reg;
    logic ctrl_run_reg;
    logic [31:0] rdata_reg;
    logic [31:0] status_word;
    logic [31:0] rdata_next;
    wire addr_phase = hsel && htrans[1] && hready;
    wire word_ok = (hsize == 3'h2) && (haddr[31:8] == 24'h000000);
    wire wr_ctrl = dp_wr_reg && (dp_addr_reg == OFS_CTRL);
    wire wr_user = dp_wr_reg && (dp_addr_reg == OFS_USERERR);
    wire err_clear = wr_ctrl && hwdata[CTRL_CLEAR_BIT];
    wire [8:0] user_num = hwdata[USER_NUM_MSB:0];
    wire user_ev = wr_user && (user_num != 9'h000);
    wire user_fatal = user_ev && hwdata[USER_FATAL_BIT];
    wire user_nonfatal = user_ev && !hwdata[USER_FATAL_BIT];
    wire [15:0] user_code = (hwdata[USER_FATAL_BIT] ? USER_FATAL_BASE
                            : USER_NONFATAL_BASE) + {7'h00, user_num};

    // unmapped addresses read zero; writes there are dropped
    always_comb begin
        if (haddr[7:0] == OFS_CTRL) begin
            rdata_next = {31'h0, ctrl_run_reg};
        end else if (haddr[7:0] == OFS_STATUS) begin
            rdata_next = status_word;
        end else if (haddr[7:0] == OFS_ERRCODE) begin
            rdata_next = {16'h0000, error_code_word};
        end else begin
            rdata_next = 32'h00000000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr_reg <= 1'b0;
            dp_addr_reg <= 8'h00;
            rdata_reg <= 32'h00000000;
        end else begin
            dp_wr_reg <= addr_phase && hwrite && word_ok;
            dp_addr_reg <= haddr[7:0];
            if (addr_phase && !hwrite) begin
                rdata_reg <= word_ok ? rdata_next : 32'h00000000;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_run_reg <= CTRL_RUN_RST;
        end else if (wr_ctrl) begin
            ctrl_run_reg <= hwdata[CTRL_RUN_BIT];
        end
    end

    assign hrdata = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ------------------------------------------------------------
    // recognition wait and lamp flash divider
    // ------------------------------------------------------------
    logic [31:0] wait_cnt_reg;
    logic [31:0] flash_cnt_reg;
    logic flash_reg;
    wire wait_done = (wait_cnt_reg >= SLOW_WAIT);
    wire all_seen = mods_recognised
                    && (!slow_unit_present || wait_done);
    wire flash_tick = (flash_cnt_reg >= FLASH_HALF - 1);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wait_cnt_reg <= 32'h00000000;
        end else if (!wait_done) begin
            wait_cnt_reg <= wait_cnt_reg + 32'h00000001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_cnt_reg <= 32'h00000000;
            flash_reg <= 1'b0;
        end else if (flash_tick) begin
            flash_cnt_reg <= 32'h00000000;
            flash_reg <= !flash_reg;
        end else begin
            flash_cnt_reg <= flash_cnt_reg + 32'h00000001;
        end
    end

    // ------------------------------------------------------------
    // error state machine
    // ------------------------------------------------------------
    ces_state_e state_reg;
    ces_state_e state_next;
    logic nonfatal_reg;
    logic pwrdn_reg;
    logic io_clear_reg;
    logic [15:0] code_reg;
    logic [15:0] code_next;
    wire operating = (state_reg == CES_RUN) || (state_reg == CES_IDLE);
    wire power_ev = rack_power_lost;
    wire hard_ev = power_ev || cpu_reset_cond;
    wire wdt_ev = wdt_timeout && (state_reg == CES_RUN) && !hard_ev;
    wire err_ok = operating && !hard_ev && !wdt_ev;
    wire fatal_ev = err_ok && (fatal_valid || user_fatal);
    wire nf_ev = err_ok && (nonfatal_valid || user_nonfatal);

    // most serious code of those raised this cycle
    wire [15:0] cand_f = fatal_valid ? fatal_code : CODE_NONE;
    wire [15:0] cand_u = user_ev ? user_code : CODE_NONE;
    wire [15:0] cand_n = nonfatal_valid ? nonfatal_code : CODE_NONE;
    wire [15:0] max_fu = (cand_f >= cand_u) ? cand_f : cand_u;
    wire [15:0] max_all = (max_fu >= cand_n) ? max_fu : cand_n;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            CES_STANDBY: begin
                if (cfg_error) begin
                    state_next = CES_CFG_STBY;
                end else if (all_seen) begin
                    state_next = ctrl_run_reg ? CES_RUN : CES_IDLE;
                end
            end
            CES_CFG_STBY: begin
                state_next = CES_CFG_STBY;
            end
            CES_IDLE, CES_RUN: begin
                if (fatal_ev) begin
                    state_next = CES_FATAL;
                end else if (state_reg == CES_IDLE && wr_ctrl
                             && hwdata[CTRL_RUN_BIT]) begin
                    state_next = CES_RUN;
                end else if (state_reg == CES_RUN && wr_ctrl
                             && !hwdata[CTRL_RUN_BIT]) begin
                    state_next = CES_IDLE;
                end
            end
            CES_FATAL: begin
                if (err_clear) begin
                    state_next = CES_IDLE;
                end
            end
            default: begin
                state_next = state_reg;
            end
        endcase
        if (hard_ev && state_reg != CES_CFG_STBY) begin
            state_next = CES_CPU_RESET;
        end else if (wdt_ev) begin
            state_next = CES_CPU_ERR;
        end
    end

    // code is set only by fatal and non-fatal events and is cleared by an error clear while in fatal or while a non-fatal error is flagged
    always_comb begin
        code_next = code_reg;
        if (fatal_ev || nf_ev) begin
            code_next = max_all;
        end else if (err_clear && !wdt_ev
                     && (state_reg == CES_FATAL || nonfatal_reg)) begin
            code_next = CODE_NONE;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= CES_STANDBY;
            code_reg <= CODE_NONE;
        end else begin
            state_reg <= state_next;
            code_reg <= code_next;
        end
    end

    // set beats clear so a fresh event is never lost
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            nonfatal_reg <= 1'b0;
            pwrdn_reg <= 1'b0;
            io_clear_reg <= 1'b0;
        end else begin
            if (nf_ev && !fatal_ev) begin
                nonfatal_reg <= 1'b1;
            end else if (err_clear || !operating) begin
                nonfatal_reg <= 1'b0;
            end
            if (power_ev) begin
                pwrdn_reg <= 1'b1;
            end
            io_clear_reg <= fatal_ev && fatal_valid;
        end
    end

    // ------------------------------------------------------------
    // lamps and outputs
    // ------------------------------------------------------------
    ces_lamp_s lamps_reg;
    ces_lamp_s lamps_next;
    logic tool_reg;
    logic outoff_reg;

    always_comb begin
        lamps_next = LAMPS_OFF;
        case (state_reg)
            CES_CFG_STBY: lamps_next = 3'b001;
            CES_IDLE: lamps_next = {2'b10, nonfatal_reg && flash_reg};
            CES_RUN: lamps_next = {2'b11, nonfatal_reg && flash_reg};
            CES_FATAL: lamps_next = 3'b101;
            CES_CPU_ERR: lamps_next = 3'b001;
            default: lamps_next = LAMPS_OFF;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lamps_reg <= LAMPS_OFF;
            tool_reg <= 1'b0;
            outoff_reg <= 1'b1;
        end else begin
            lamps_reg <= lamps_next;
            tool_reg <= (state_reg != CES_CPU_ERR)
                        && (state_reg != CES_CPU_RESET);
            outoff_reg <= (state_reg != CES_RUN);
        end
    end

    assign lamps = lamps_reg;
    assign tool_connect_ok = tool_reg;
    assign outputs_off = outoff_reg;
    assign cycle_enable = (state_reg == CES_RUN) && !outoff_reg;
    assign io_mem_clear = io_clear_reg;
    assign power_down_req = pwrdn_reg;
    assign error_code_word = code_reg;
    assign status_word = {21'h0, pwrdn_reg, nonfatal_reg, outoff_reg,
                          tool_reg, lamps_reg, 1'b0, state_reg};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_wdt_hit;
        state_reg == CES_RUN && wdt_timeout && !hard_ev;
    endsequence

    sequence s_cpu_err_shown;
        lamps == 3'b001 && !tool_connect_ok;
    endsequence

    a_wdt_cpu_err: assert property (s_wdt_hit |-> ##2 s_cpu_err_shown)
        else $error("watchdog did not give cpu error indication");
    a_wdt_no_code: assert property (s_wdt_hit |=> $stable(code_reg))
        else $error("watchdog changed the error code");
    a_fatal_lamps: assert property (
        state_reg == CES_FATAL |=> lamps == 3'b101 && tool_connect_ok)
        else $error("fatal indication wrong");
    a_reset_lamps: assert property (
        hard_ev && state_reg != CES_CFG_STBY
        |-> ##2 lamps == LAMPS_OFF && !tool_connect_ok)
        else $error("cpu reset indication wrong");
    a_rack_power: assert property (
        rack_power_lost |=> power_down_req
        && state_reg inside {CES_CPU_RESET, CES_CFG_STBY})
        else $error("rack power loss not handled");
    a_no_early_run: assert property (
        state_reg == CES_STANDBY && !all_seen |=> !cycle_enable)
        else $error("servicing started before recognition");
    a_standby_dark: assert property (
        state_reg == CES_STANDBY |=> lamps == LAMPS_OFF
        && error_code_word == CODE_NONE)
        else $error("standby indication wrong");
    a_cfg_latched: assert property (
        state_reg == CES_CFG_STBY |=> state_reg == CES_CFG_STBY
        ##1 lamps.err)
        else $error("configuration standby left");
    a_slow_wait: assert property (
        state_reg == CES_STANDBY && slow_unit_present && !wait_done
        |=> state_reg inside {CES_STANDBY, CES_CFG_STBY, CES_CPU_RESET})
        else $error("standby left before slow unit wait");
    a_code_max: assert property (
        fatal_ev && nonfatal_valid && !user_ev && fatal_code >= nonfatal_code
        |=> error_code_word == $past(fatal_code))
        else $error("most serious code not stored");
    a_io_clear: assert property (
        fatal_ev |=> io_mem_clear == $past(fatal_valid))
        else $error("io memory clear wrong");
    a_outputs_off: assert property (
        state_reg != CES_RUN |=> outputs_off && !cycle_enable)
        else $error("outputs not forced off");
    a_nonfatal_run: assert property (
        state_reg == CES_RUN && nf_ev && !fatal_ev && !wr_ctrl
        |=> state_reg == CES_RUN ##1 lamps.rdy && lamps.run)
        else $error("non-fatal error stopped operation");
    a_fatal_hold: assert property (
        state_reg == CES_FATAL && !err_clear && !hard_ev
        |=> state_reg == CES_FATAL && $stable(code_reg))
        else $error("fatal state not held");

endmodule // ces_error_status

`default_nettype wire

// >>> dv/ces_mod_partner.sv
`timescale 1ns/1ps
`default_nettype none

// -----------------------------------------------------------------
// attached modules: announce recognition after a set delay
// -----------------------------------------------------------------
module ces_mod_partner (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [15:0] recog_delay,
    output logic mods_recognised
);
    logic [15:0] cnt_reg;

    // delay picked by the bench per run, so prompt and slow starts occur
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_reg <= 16'h0000;
            mods_recognised <= 1'b0;
        end else begin
            if (cnt_reg != recog_delay) begin
                cnt_reg <= cnt_reg + 16'h0001;
            end
            mods_recognised <= (cnt_reg == recog_delay);
        end
    end
endmodule // ces_mod_partner

`default_nettype wire

// >>> dv/ces_error_status_bench.sv
`timescale 1ns/1ps
`default_nettype none

module ces_error_status_bench;
    import ces_pkg::*;
    localparam int unsigned SW = 50;
    localparam int unsigned FH = 4;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic slow, cfg_err, wdt, cpu_rst, rack, fv, nfv, recog;
    logic tool_ok, ce, oo, iomc, pdr, prev_err;
    logic [15:0] fcode, nfcode, code_w, rdelay, nf, fc;
    logic [8:0] un;
    ces_lamp_s lamps;
    int bad_count, checked, cyc, cyc0, clr_cnt, tog, seed;
    logic [15:0] ftab [4] = '{16'h80F1, 16'h80C0, 16'h80E9, 16'h809F};

    ces_mod_partner partner (.hclk(hclk), .hresetn(hresetn),
        .recog_delay(rdelay), .mods_recognised(recog));
    ces_error_status #(.SLOW_WAIT(SW), .FLASH_HALF(FH)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .mods_recognised(recog), .slow_unit_present(slow),
        .cfg_error(cfg_err), .wdt_timeout(wdt), .cpu_reset_cond(cpu_rst),
        .rack_power_lost(rack), .fatal_valid(fv), .fatal_code(fcode),
        .nonfatal_valid(nfv), .nonfatal_code(nfcode), .lamps(lamps),
        .tool_connect_ok(tool_ok), .cycle_enable(ce), .outputs_off(oo),
        .io_mem_clear(iomc), .power_down_req(pdr), .error_code_word(code_w));

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------
    function automatic logic [15:0] exp_code(input logic [15:0] a,
                                             input logic [15:0] b);
        return (a > b) ? a : b;
    endfunction

    function automatic logic [15:0] user_code(input logic f,
                                              input logic [8:0] n);
        return (f ? USER_FATAL_BASE : USER_NONFATAL_BASE) + {7'h00, n};
    endfunction

    task automatic finish_test();
        $display("checked %0d bad_count %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            bad_count++;
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    // one single word transfer; zero wait states are not assumed
    task automatic ahb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'b10;
        hwrite <= w;
        hsize <= 3'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic do_reset(input logic s, input logic [15:0] dl);
        @(posedge hclk);
        hresetn <= 1'b0;
        slow <= s;
        rdelay <= dl;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        cyc0 = cyc;
    endtask

    task automatic wait_run();
        int n;
        n = 0;
        while (ce !== 1'b1 && n < 300) begin
            @(posedge hclk);
            n++;
        end
        #1;
    endtask

    task automatic pulse(input logic f, input logic n, input logic w,
                         input logic [15:0] fcv, input logic [15:0] ncv);
        @(posedge hclk);
        fv <= f;
        nfv <= n;
        wdt <= w;
        fcode <= fcv;
        nfcode <= ncv;
        @(posedge hclk);
        fv <= 1'b0;
        nfv <= 1'b0;
        wdt <= 1'b0;
    endtask

    // -----------------------------------------------------------------
    // clock, monitors, timeout
    // -----------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cyc++;
        if (iomc === 1'b1) clr_cnt++;
        if (lamps.err !== prev_err) tog++;
        prev_err = lamps.err;
        if (cyc == 20000) begin
            bad_count++;
            finish_test();
        end
    end

    // -----------------------------------------------------------------
    // scenarios
    // -----------------------------------------------------------------
    initial begin
        {hresetn, hsel, hwrite, slow, cfg_err, wdt, cpu_rst} = 7'h00;
        {rack, fv, nfv} = 3'h0;
        {haddr, hwdata} = 64'h0;
        {htrans, hsize, fcode, nfcode, rdelay} = 53'h0;
        {bad_count, checked, cyc, cyc0, clr_cnt, tog} = '0;
        seed = 76867;
        do_reset(1'b1, 16'h0005);
        tick(30);
        chk(ce, 1'b0);
        chk(lamps, LAMPS_OFF);
        chk(code_w, CODE_NONE);
        wait_run();
        chk(ce, 1'b1);
        chk(cyc - cyc0 >= SW, 1'b1);
        $display("test startup done");
        nf = {4'h0, 12'($random(seed))} | 16'h0001;
        pulse(1'b0, 1'b1, 1'b0, 16'h0000, nf);
        tick(3);
        chk(code_w, nf);
        chk({lamps.rdy, lamps.run}, 2'b11);
        tog = 0;
        tick(12);
        chk(tog >= 2, 1'b1);
        chk(ce, 1'b1);
        $display("test nonfatal done");
        fc = ftab[2'($random(seed))];
        clr_cnt = 0;
        pulse(1'b1, 1'b1, 1'b0, fc, nf);
        tick(3);
        chk(code_w, exp_code(fc, nf));
        chk(clr_cnt, 1);
        chk(lamps, 3'b101);
        chk(tool_ok, 1'b1);
        chk({oo, ce}, 2'b10);
        tick(20);
        chk({lamps, code_w}, {3'b101, exp_code(fc, nf)});
        $display("test fatal done");
        ahb(1'b1, OFS_CTRL, 32'h00000002);
        ahb(1'b0, OFS_STATUS, 32'h00000000);
        chk(rd[2:0], CES_IDLE);
        ahb(1'b1, OFS_CTRL, 32'h00000001);
        wait_run();
        chk(ce, 1'b1);
        un = 9'($random(seed)) | 9'h001;
        clr_cnt = 0;
        ahb(1'b1, OFS_USERERR, {15'h0000, 1'b1, 7'h00, un});
        tick(3);
        chk(code_w, user_code(1'b1, un));
        chk(clr_cnt, 0);
        chk(oo, 1'b1);
        ahb(1'b0, OFS_ERRCODE, 32'h00000000);
        chk(rd, {16'h0000, user_code(1'b1, un)});
        $display("test user fatal done");
        ahb(1'b1, OFS_CTRL, 32'h00000002);
        ahb(1'b1, OFS_CTRL, 32'h00000001);
        wait_run();
        pulse(1'b0, 1'b0, 1'b1, 16'h0000, 16'h0000);
        tick(3);
        chk({lamps, tool_ok, code_w}, {3'b001, 1'b0, CODE_NONE});
        chk({oo, ce}, 2'b10);
        $display("test watchdog done");
        do_reset(1'b0, 16'h0005);
        wait_run();
        @(posedge hclk);
        cpu_rst <= 1'b1;
        tick(3);
        chk({lamps, tool_ok, code_w}, {3'b000, 1'b0, CODE_NONE});
        @(posedge hclk);
        cpu_rst <= 1'b0;
        $display("test cpu reset done");
        do_reset(1'b0, 16'h0005);
        wait_run();
        @(posedge hclk);
        rack <= 1'b1;
        tick(3);
        chk({pdr, ce}, 2'b10);
        chk(oo, 1'b1);
        @(posedge hclk);
        rack <= 1'b0;
        $display("test rack power done");
        do_reset(1'b0, 16'h0028);
        tick(2);
        @(posedge hclk);
        cfg_err <= 1'b1;
        @(posedge hclk);
        cfg_err <= 1'b0;
        tick(60);
        chk({lamps, ce}, {3'b001, 1'b0});
        ahb(1'b0, 8'h40, 32'h00000000);
        chk(rd, 32'h00000000);
        $display("test config error done");
        finish_test();
    end
endmodule // ces_error_status_bench

`default_nettype wire
